/* File: sflrc_config_regs.sv */
// configuration bank: lock pin, settle wait and mute, reference and keying setup
// What this block does
// - lock bit 3 picks readback or lock on pin
// - lock bit 0 enables lock detection, reset off
// - settle count bits 13-3, reference cycles, reset C8h
// - every frequency switch includes the settle wait
// - mute bit holds outputs muted until lock
// - bits 1/0 pick transmit/receive driver style
// - bit 15 enables termination on both inputs
// - bit 14 picks single-ended or differential input
// - bits 13-11 pick crystal series resistor
// - crystal enable overrides input style selection
// - bit 8 sets frame sync polarity
// - bit 7 sets serial clock sampling edge
// - bits 6-5 set keying level count
// - bits 4-2 pick deviation slot for SPI
// - two select bits choose the keying source
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module sflrc_config_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic referenceInput,
  input wire logic lockIndication,
  input wire logic readbackData,
  input wire logic vcoChange,
  input wire logic profileSwitching,
  input wire logic profileKeyingEnable,
  output logic multiplexedOutputPin,
  output logic outputsMuted,
  output logic switchBusy,
  output logic transmitDriverStyle,
  output logic receiveDriverStyle,
  output sflrc_pkg::sflrc_ref_type refConfig,
  output sflrc_pkg::sflrc_key_type keyConfig
);
  typedef enum logic [3:0] {
    SW_SETTLE = 4'h1,
    SW_LOCKWAIT = 4'h2,
    SW_RUN = 4'h4,
    SW_START = 4'h8
  } sflrc_sw_type;

  logic [15:0] refKeyReg;
  logic [15:0] multWaitReg;
  logic [15:0] lockPinReg;
  logic [15:0] statusWord;
  logic [2:0] refSync;
  logic [2:0] lockSync;
  logic refLevel;
  logic lockLevel;
  logic refEdge;
  logic locked;
  logic [10:0] settleCnt;
  logic released;
  sflrc_sw_type swState;
  logic setupPhase;
  logic accessDone;
  logic [7:0] regIdx;
  logic [1:0] src;
  logic [1:0] lvl;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return a[1:0] == 2'h0 && (a[9:2] == sflrc_pkg::IDX_REF_KEY
      || a[9:2] == sflrc_pkg::IDX_MULTIPLIER_SETTLE_COUNT || a[9:2] == sflrc_pkg::IDX_LOCK_PIN
      || a[9:2] == sflrc_pkg::IDX_STATUS) && a[11:10] == 2'h0;
  endfunction

  assign regIdx = paddr[9:2];
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready;

  // bus answer: one wait-free access phase, data captured in the setup cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (setupPhase) begin
      pready <= 1'b1;
      pslverr <= !mapped(paddr);
      if (!pwrite && mapped(paddr)) begin
        unique case (regIdx)
          sflrc_pkg::IDX_REF_KEY: prdata <= {16'h0, refKeyReg};
          sflrc_pkg::IDX_MULTIPLIER_SETTLE_COUNT: prdata <= {16'h0, multWaitReg};
          sflrc_pkg::IDX_LOCK_PIN: prdata <= {16'h0, lockPinReg};
          default: prdata <= {16'h0, statusWord};
        endcase
      end else begin
        prdata <= 32'h0;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // register writes take effect at the completing edge; reserved fields stored as written
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refKeyReg <= sflrc_pkg::RST_REF_KEY;
      multWaitReg <= sflrc_pkg::RST_MULTIPLIER_SETTLE_COUNT;
      lockPinReg <= sflrc_pkg::RST_LOCK_PIN;
    end else if (accessDone && pwrite && !pslverr) begin
      if (regIdx == sflrc_pkg::IDX_REF_KEY) begin
        refKeyReg <= merge(refKeyReg, pwdata, pstrb);
      end
      if (regIdx == sflrc_pkg::IDX_MULTIPLIER_SETTLE_COUNT) begin
        multWaitReg <= merge(multWaitReg, pwdata, pstrb);
      end
      if (regIdx == sflrc_pkg::IDX_LOCK_PIN) begin
        lockPinReg <= merge(lockPinReg, pwdata, pstrb);
      end
    end
  end

  assign statusWord = {11'h0, released, switchBusy, outputsMuted, lockLevel, refLevel};

  // pin synchronisers; a level is accepted once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refSync <= 3'h0;
      lockSync <= 3'h0;
      refLevel <= 1'b0;
      lockLevel <= 1'b0;
    end else begin
      refSync <= {refSync[1:0], referenceInput};
      lockSync <= {lockSync[1:0], lockIndication};
      if (refSync[2] == refSync[1]) begin
        refLevel <= refSync[2];
      end
      if (lockSync[2] == lockSync[1]) begin
        lockLevel <= lockSync[2];
      end
    end
  end

  assign refEdge = refSync[2] && refSync[1] && !refLevel;
  assign locked = lockLevel && lockPinReg[sflrc_pkg::LK_ON_BIT];

  // frequency switch sequence: settle wait, then wait for lock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      swState <= SW_START;
      settleCnt <= 11'h0;
    end else begin
      unique case (swState)
        SW_START: begin
          settleCnt <= multWaitReg[sflrc_pkg::MW_CNT_MSB:sflrc_pkg::MW_CNT_LSB];
          swState <= SW_SETTLE;
        end
        SW_SETTLE: begin
          if (vcoChange || profileSwitching) begin
            settleCnt <= multWaitReg[sflrc_pkg::MW_CNT_MSB:sflrc_pkg::MW_CNT_LSB];
          end else if (settleCnt <= 11'h1 && refEdge) begin
            settleCnt <= 11'h0;
            swState <= SW_LOCKWAIT;
          end else if (refEdge) begin
            settleCnt <= settleCnt - 11'h1;
          end
        end
        SW_LOCKWAIT: begin
          if (vcoChange || profileSwitching) begin
            swState <= SW_START;
          end else if (locked) begin
            swState <= SW_RUN;
          end
        end
        SW_RUN: begin
          if (vcoChange || profileSwitching) begin
            swState <= SW_START;
          end
        end
        default: swState <= SW_START;
      endcase
    end
  end

  // mute until lock; once released a later loss of lock leaves outputs on
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      released <= 1'b0;
      outputsMuted <= 1'b1;
      switchBusy <= 1'b1;
    end else begin
      switchBusy <= swState != SW_RUN;
      if (swState == SW_LOCKWAIT && locked) begin
        released <= 1'b1;
      end else if (swState == SW_START) begin
        released <= 1'b0;
      end
      outputsMuted <= multWaitReg[sflrc_pkg::MW_MUTE_BIT] && !released
        && swState != SW_RUN;
    end
  end

  // select bit 0 of the register is the high bit of the source code
  assign src = {refKeyReg[sflrc_pkg::RK_SRC1_BIT], refKeyReg[sflrc_pkg::RK_SRC0_BIT]};
  assign lvl = refKeyReg[sflrc_pkg::RK_LVL_MSB:sflrc_pkg::RK_LVL_LSB];

  // registered copies of the configuration driven to the analog and keying logic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      multiplexedOutputPin <= 1'b0;
      transmitDriverStyle <= 1'b1;
      receiveDriverStyle <= 1'b1;
      refConfig <= '0;
      keyConfig <= '0;
    end else begin
      multiplexedOutputPin <= lockPinReg[sflrc_pkg::LK_SEL_BIT] ? locked
        : readbackData;
      transmitDriverStyle <= multWaitReg[sflrc_pkg::MW_TX_BIT];
      receiveDriverStyle <= multWaitReg[sflrc_pkg::MW_RX_BIT];
      refConfig.terminationOn <= refKeyReg[sflrc_pkg::RK_TERM_BIT];
      refConfig.differential <= refKeyReg[sflrc_pkg::RK_DIFF_BIT]
        && !refKeyReg[sflrc_pkg::RK_XTAL_BIT];
      refConfig.crystalOn <= refKeyReg[sflrc_pkg::RK_XTAL_BIT];
      refConfig.seriesResistor <= refKeyReg[sflrc_pkg::RK_XRES_MSB:sflrc_pkg::RK_XRES_LSB];
      keyConfig.source <= src;
      keyConfig.levels <= lvl;
      keyConfig.slot <= refKeyReg[sflrc_pkg::RK_SLOT_MSB:sflrc_pkg::RK_SLOT_LSB];
      keyConfig.frameSyncActiveLow <= refKeyReg[sflrc_pkg::RK_FS_BIT];
      keyConfig.clockFallingEdge <= refKeyReg[sflrc_pkg::RK_CLK_BIT];
      keyConfig.active <= profileKeyingEnable && (lvl != 2'h0
        || src == sflrc_pkg::SRC_I2S || src == sflrc_pkg::SRC_FAST);
    end
  end

  chk_pin_lock_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lockPinReg[sflrc_pkg::LK_SEL_BIT] |=> multiplexedOutputPin == $past(locked))
    else $error("output pin does not follow lock");
  chk_pin_readback_src: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !lockPinReg[sflrc_pkg::LK_SEL_BIT] |=> multiplexedOutputPin == $past(readbackData))
    else $error("output pin does not follow readback");
  chk_lock_off_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !lockPinReg[sflrc_pkg::LK_ON_BIT] && swState == SW_LOCKWAIT |=> swState != SW_RUN)
    else $error("lock accepted while detection off");
  chk_settle_before_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    swState == SW_START |=> swState == SW_SETTLE ##1 swState != SW_RUN)
    else $error("switch skipped settle wait");
  chk_settle_ends_on_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
    swState == SW_SETTLE && !refEdge |=> swState != SW_LOCKWAIT)
    else $error("settle ended without reference edge");
  chk_mute_until_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    multWaitReg[sflrc_pkg::MW_MUTE_BIT] && swState == SW_SETTLE && !released
    |=> outputsMuted)
    else $error("outputs live before lock");
  chk_no_remute: assert property (@(posedge sys_clk) disable iff (!rst_n)
    swState == SW_RUN && !lockLevel |=> !outputsMuted)
    else $error("outputs muted again after release");
  chk_crystal_override: assert property (@(posedge sys_clk) disable iff (!rst_n)
    refKeyReg[sflrc_pkg::RK_XTAL_BIT] |=> !refConfig.differential)
    else $error("crystal does not override input style");
  chk_zero_level_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lvl == 2'h0 && !src[1] |=> !keyConfig.active)
    else $error("keying active with zero levels");
endmodule

/* File: sflrc_pkg.sv */
// shared constants and carrier types for the synthesizer configuration bank
package sflrc_pkg;
  // register indexes; byte address on the bus is four times the index
  localparam logic [7:0] IDX_REF_KEY = 8'h22;
  localparam logic [7:0] IDX_MULTIPLIER_SETTLE_COUNT = 8'h23;
  localparam logic [7:0] IDX_LOCK_PIN = 8'h27;
  localparam logic [7:0] IDX_STATUS = 8'h28;
  localparam logic [15:0] RST_REF_KEY = 16'h1000;
  localparam logic [15:0] RST_MULTIPLIER_SETTLE_COUNT = 16'h0647;
  localparam logic [15:0] RST_LOCK_PIN = 16'h11f0;
  // field positions
  localparam int LK_SEL_BIT = 3;
  localparam int LK_ON_BIT = 0;
  localparam int MW_CNT_LSB = 3;
  localparam int MW_CNT_MSB = 13;
  localparam int MW_MUTE_BIT = 2;
  localparam int MW_TX_BIT = 1;
  localparam int MW_RX_BIT = 0;
  localparam int RK_TERM_BIT = 15;
  localparam int RK_DIFF_BIT = 14;
  localparam int RK_XRES_LSB = 11;
  localparam int RK_XRES_MSB = 13;
  localparam int RK_XTAL_BIT = 10;
  localparam int RK_FS_BIT = 8;
  localparam int RK_CLK_BIT = 7;
  localparam int RK_LVL_LSB = 5;
  localparam int RK_LVL_MSB = 6;
  localparam int RK_SLOT_LSB = 2;
  localparam int RK_SLOT_MSB = 4;
  localparam int RK_SRC0_BIT = 1;
  localparam int RK_SRC1_BIT = 0;
  // keying source codes
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_SPI = 2'h1;
  localparam logic [1:0] SRC_I2S = 2'h2;
  localparam logic [1:0] SRC_FAST = 2'h3;

  typedef struct packed {
    logic terminationOn;
    logic differential;
    logic crystalOn;
    logic [2:0] seriesResistor;
  } sflrc_ref_type;

  typedef struct packed {
    logic active;
    logic [1:0] source;
    logic [1:0] levels;
    logic [2:0] slot;
    logic frameSyncActiveLow;
    logic clockFallingEdge;
  } sflrc_key_type;
endpackage

/* File: tb_top.sv */
// self-checking bench for the synthesizer configuration bank
`timescale 1ns/1ps
module tb_top;
  logic sysClk = 0, rstN = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'h3;
  logic pready, pslverr, refIn = 0, lockIn = 0, rbData = 0, vcoChange = 0, profSw = 0, pke = 0;
  logic muxPin, muted, busy, txStyle, rxStyle;
  sflrc_pkg::sflrc_ref_type refConfig;
  sflrc_pkg::sflrc_key_type keyConfig;
  logic [32:0] expQ[$];
  int n_mismatch = 0, tests_run = 0;
  logic [15:0] v;
  logic [1:0] src;
  always #2 sysClk = ~sysClk;
  sflrc_config_regs DUT (.sys_clk(sysClk), .rst_n(rstN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .referenceInput(refIn), .lockIndication(lockIn),
    .readbackData(rbData), .vcoChange(vcoChange), .profileSwitching(profSw),
    .profileKeyingEnable(pke), .multiplexedOutputPin(muxPin), .outputsMuted(muted),
    .switchBusy(busy), .transmitDriverStyle(txStyle), .receiveDriverStyle(rxStyle),
    .refConfig(refConfig), .keyConfig(keyConfig));
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] d);
    int n;
    @(posedge sysClk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge sysClk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sysClk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic err, input logic [15:0] d);
    expQ.push_back({err, 16'h0000, d});
    xfer(1'b0, a, 16'h0000);
  endtask
  // n slow reference periods, each long enough to pass the synchronizer
  task automatic refEdges(input int n);
    repeat (n) begin
      repeat (3) @(posedge sysClk) refIn <= 1'b1;
      repeat (3) @(posedge sysClk) refIn <= 1'b0;
    end
  endtask
  always @(posedge sysClk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expQ.size() == 0) chk("apb read unexpected", 33'h0, 33'h1);
      else chk("apb read", expQ.pop_front(), {pslverr, prdata});
    end
  end
  task automatic give_verdict;
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #80000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    int n;
    void'($urandom(6));
    repeat (2) @(posedge sysClk);
    rstN <= 1'b1;
    rd(12'h088, 1'b0, 16'h1000);
    rd(12'h08c, 1'b0, 16'h0647);
    rd(12'h09c, 1'b0, 16'h11f0);
    rd(12'h040, 1'b1, 16'h0000);
    chk("txStyle", 1, txStyle);
    chk("rxStyle", 1, rxStyle);
    chk("seriesResistor", 2, refConfig.seriesResistor);
    chk("muted", 1, muted);
    // readback data routed to the pin
    xfer(1'b1, 12'h09c, 16'h11f3);
    @(posedge sysClk) rbData <= 1'b1;
    repeat (3) @(posedge sysClk);
    chk("pin readback", 1, muxPin);
    rbData <= 1'b0;
    repeat (3) @(posedge sysClk);
    chk("pin readback", 0, muxPin);
    lockIn <= 1'b1;
    xfer(1'b1, 12'h09c, 16'h11fb);
    repeat (8) @(posedge sysClk);
    chk("pin lock", 1, muxPin);
    xfer(1'b1, 12'h09c, 16'h11fa);
    repeat (3) @(posedge sysClk);
    chk("pin lock off", 0, muxPin);
    xfer(1'b1, 12'h09c, 16'h11fb);
    // settle count of 3 reference cycles, mute on, both push-pull
    xfer(1'b1, 12'h08c, 16'h001f);
    @(posedge sysClk) vcoChange <= 1'b1;
    @(posedge sysClk) vcoChange <= 1'b0;
    refEdges(2);
    repeat (6) @(posedge sysClk);
    chk("busy in settle", 1, busy);
    chk("muted in settle", 1, muted);
    refEdges(1);
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(posedge sysClk);
      n++;
    end
    chk("settle done", 1, n < 40);
    chk("released", 0, muted);
    lockIn <= 1'b0;
    repeat (10) @(posedge sysClk);
    chk("no remute", 0, muted);
    rd(12'h0a0, 1'b0, 16'h0010);
    // 2000 reference cycles cover 20 us at 100 MHz; driver styles split
    xfer(1'b1, 12'h08c, 16'h3e86);
    rd(12'h08c, 1'b0, 16'h3e86);
    repeat (3) @(posedge sysClk);
    chk("txStyle", 1, txStyle);
    chk("rxStyle", 0, rxStyle);
    xfer(1'b1, 12'h08c, 16'h3e85);
    repeat (3) @(posedge sysClk);
    chk("txStyle", 0, txStyle);
    chk("rxStyle", 1, rxStyle);
    // every level count and every keying source
    for (int i = 0; i < 16; i++) begin
      v = 16'($urandom);
      v[13] = 1'b0;
      v[9] = 1'b0;
      v[6:5] = 2'(i);
      {v[0], v[1]} = 2'(i >> 2);
      src = {v[0], v[1]};
      pke <= 1'($urandom);
      xfer(1'b1, 12'h088, v);
      rd(12'h088, 1'b0, v);
      repeat (3) @(posedge sysClk);
      chk("refConfig", {v[15], v[14] & ~v[10], v[10], v[13:11]}, refConfig);
      chk("keyConfig", {pke & ((v[6:5] != 2'h0) | src[1]), src, v[6:2], v[8], v[7]},
        keyConfig);
    end
    give_verdict;
  end
endmodule
